//--- src/tsm_slave.sv
// Two-wire serial memory slave front end and its write buffer.
// Assumes a synchronous array: read data valid one clock after mem_rd_addr,
// and a write sink on the same clock draining mem_wr_* by valid/ready.
// Functional notes
// - Address word: type, select, top bit, direction.
// - Only matching type code addresses this device.
// - Select bits high then low match straps.
// - Seventh word bit is address bit 16.
// - Eighth bit zero writes, one reads.
// - Mismatch: no acknowledge, ignore until start.
// - Match: pull data low in ninth clock.
// - Two address bytes, high first, each acknowledged.
// - Master clocks; direction picks data driver.
// - Write bytes acknowledged unless buffer full; master then sends next.
// - Read: eight bits out, release for ack.
// - Never busy; new address word acknowledged immediately.
// - Write-lock high at commit keeps the byte out of the buffer; bytes already buffered still drain to the array.
// - Reads work whatever the write-lock level.
// - Byte write: word, two addresses, data, stop.
// - Page write increments address, wraps to zero.
// - Byte committed when its acknowledge ends.
// - Seventeen-bit address buffer kept across transfers.
// - Current read: top bit from the word, low bits from the buffered address (already one past the last byte), wrapping.
// - Random read: set address, restart, one byte.
// - Sequential read increments while master acknowledges.
// - Sample on clock rise, drive on fall.
// - Stop before acknowledge abandons transfer, standby.
`timescale 1ns/1ns

module tsm_fifo #(
    parameter int WIDTH = 25,
    parameter int DEPTH = 32
) (
    input wire logic clk_sys,
    input wire logic rst_sync_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] wr;
        logic [AW:0] rd;
    } tsm_fifo_s;

    tsm_fifo_s r;
    tsm_fifo_s n;
    logic [WIDTH-1:0] mem [DEPTH];
    logic full;
    logic empty;

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
        $error("tsm_fifo: DEPTH must be a power of two of at least 2");
    end

    assign full = (r.wr[AW] != r.rd[AW]) && (r.wr[AW-1:0] == r.rd[AW-1:0]);
    assign empty = (r.wr == r.rd);
    assign in_ready = ~full;
    assign out_valid = ~empty;
    assign out_data = mem[r.rd[AW-1:0]];

    always_comb begin
        n = r;
        if (in_valid && !full) begin
            n.wr = r.wr + 1'b1;
        end
        if (out_ready && !empty) begin
            n.rd = r.rd + 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (in_valid && !full) begin
            mem[r.wr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
endmodule // tsm_fifo

module tsm_slave #(
    parameter logic [3:0] TYPE_CODE = 4'h6, // Arbitrary value
    parameter int WR_DEPTH = tsm_pkg::FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic wp_in,
    input wire logic select_pin_high,
    input wire logic select_pin_low,
    output logic mem_wr_valid,
    input wire logic mem_wr_ready,
    output tsm_pkg::tsm_wr_word_s mem_wr_word,
    output logic mem_rd_en,
    output logic [tsm_pkg::ADDR_W-1:0] mem_rd_addr,
    input wire logic [tsm_pkg::BYTE_W-1:0] mem_rd_data,
    output logic busy
);
    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic [1:0] rst_pipe;
    logic rst_sync_n;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_pipe[1];

    // ----------------------------------------------------------------
    // State and bus events
    // ----------------------------------------------------------------
    tsm_pkg::tsm_state_s r;
    tsm_pkg::tsm_state_s n;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic [tsm_pkg::BYTE_W-1:0] rx_byte;
    logic addr_match;
    logic push;
    logic fifo_ready;
    tsm_pkg::tsm_wr_word_s push_word;

    assign scl_rise = r.scl_s & ~r.scl_d;
    assign scl_fall = ~r.scl_s & r.scl_d;
    assign start_cond = r.scl_s & r.scl_d & r.sda_d & ~r.sda_s;
    assign stop_cond = r.scl_s & r.scl_d & ~r.sda_d & r.sda_s;
    assign rx_byte = {r.shift[tsm_pkg::BYTE_W-2:0], r.sda_s};
    assign addr_match = (rx_byte[tsm_pkg::TYPE_MSB:tsm_pkg::TYPE_LSB] == TYPE_CODE)
        && (rx_byte[tsm_pkg::SEL_HIGH_POS] == r.selh_s)
        && (rx_byte[tsm_pkg::SEL_LOW_POS] == r.sell_s);
    assign push_word = '{addr: r.next, data: r.wbyte};

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        n = r;
        push = 1'b0;
        n.rd_en = 1'b0;
        n.scl_m = scl_in;
        n.scl_s = r.scl_m;
        n.scl_d = r.scl_s;
        n.sda_m = sda_in;
        n.sda_s = r.sda_m;
        n.sda_d = r.sda_s;
        n.wp_m = wp_in;
        n.wp_s = r.wp_m;
        n.selh_m = select_pin_high;
        n.selh_s = r.selh_m;
        n.sell_m = select_pin_low;
        n.sell_s = r.sell_m;
        if (start_cond) begin
            // Always ready for a fresh address word, even right after writes
            n.st = tsm_pkg::ST_DEVADDR;
            n.cnt = 4'h0;
            n.oe = 1'b0;
            n.ack = 1'b0;
        end else if (stop_cond) begin
            // Address buffer survives; any unfinished byte is dropped
            n.st = tsm_pkg::ST_IDLE;
            n.cnt = 4'h0;
            n.oe = 1'b0;
            n.ack = 1'b0;
        end else if (r.st != tsm_pkg::ST_IDLE && r.st != tsm_pkg::ST_IGNORE) begin
            if (scl_rise) begin
                if (r.cnt < tsm_pkg::ACK_SLOT) begin
                    n.shift = rx_byte;
                    n.cnt = r.cnt + 4'h1;
                    if (r.cnt == tsm_pkg::LAST_DATA_SLOT) begin
                        unique case (r.st)
                            tsm_pkg::ST_DEVADDR: begin
                                if (addr_match) begin
                                    n.ack = 1'b1;
                                    n.top = rx_byte[tsm_pkg::TOP_ADDR_POS];
                                    n.dir = rx_byte[tsm_pkg::DIR_POS];
                                    if (rx_byte[tsm_pkg::DIR_POS] == tsm_pkg::DIR_READ) begin
                                        // Top bit from the word, low bits from buffer
                                        n.rd_addr = {rx_byte[tsm_pkg::TOP_ADDR_POS],
                                            r.next[tsm_pkg::ADDR_W-2:0]};
                                        n.rd_en = 1'b1;
                                    end
                                end else begin
                                    n.st = tsm_pkg::ST_IGNORE;
                                end
                            end
                            tsm_pkg::ST_ADDR_HI: begin
                                n.hi = rx_byte;
                                n.ack = 1'b1;
                            end
                            tsm_pkg::ST_ADDR_LO: begin
                                n.next = {r.top, r.hi, rx_byte};
                                n.ack = 1'b1;
                            end
                            tsm_pkg::ST_WDATA: begin
                                n.wbyte = rx_byte;
                                // Full buffer is the only reason to refuse a byte
                                n.ack = fifo_ready;
                            end
                            default: begin
                            end
                        endcase
                    end
                end else if (r.cnt == tsm_pkg::ACK_SLOT) begin
                    n.cnt = tsm_pkg::ACK_DONE_SLOT;
                    if (r.st == tsm_pkg::ST_RDATA) begin
                        n.mack = ~r.sda_s;
                        if (!r.sda_s) begin
                            n.rd_addr = r.next;
                            n.rd_en = 1'b1;
                        end
                    end
                end
            end else if (scl_fall) begin
                if (r.cnt == tsm_pkg::ACK_SLOT) begin
                    // Read: let go so the master can answer
                    n.oe = (r.st == tsm_pkg::ST_RDATA) ? 1'b0 : r.ack;
                end else if (r.cnt == tsm_pkg::ACK_DONE_SLOT) begin
                    n.cnt = 4'h0;
                    n.oe = 1'b0;
                    n.ack = 1'b0;
                    unique case (r.st)
                        tsm_pkg::ST_DEVADDR: begin
                            if (r.dir == tsm_pkg::DIR_READ) begin
                                n.st = tsm_pkg::ST_RDATA;
                                n.tx = mem_rd_data;
                                n.oe = ~mem_rd_data[tsm_pkg::BYTE_W-1];
                                n.next = r.rd_addr + 17'h00001;
                            end else begin
                                n.st = tsm_pkg::ST_ADDR_HI;
                            end
                        end
                        tsm_pkg::ST_ADDR_HI: begin
                            n.st = tsm_pkg::ST_ADDR_LO;
                        end
                        tsm_pkg::ST_ADDR_LO: begin
                            n.st = tsm_pkg::ST_WDATA;
                        end
                        tsm_pkg::ST_WDATA: begin
                            if (r.ack) begin
                                // Commit at the end of the acknowledge clock
                                push = ~r.wp_s;
                                n.next = r.next + 17'h00001;
                            end else begin
                                n.st = tsm_pkg::ST_IGNORE;
                            end
                        end
                        tsm_pkg::ST_RDATA: begin
                            if (r.mack) begin
                                n.tx = mem_rd_data;
                                n.oe = ~mem_rd_data[tsm_pkg::BYTE_W-1];
                                n.next = r.rd_addr + 17'h00001;
                            end else begin
                                n.st = tsm_pkg::ST_IGNORE;
                            end
                        end
                        default: begin
                        end
                    endcase
                end else if (r.st == tsm_pkg::ST_RDATA) begin
                    // Next data bit goes out on the falling edge
                    n.tx = {r.tx[tsm_pkg::BYTE_W-2:0], 1'b0};
                    n.oe = ~r.tx[tsm_pkg::BYTE_W-2];
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            r <= '{st: tsm_pkg::ST_IDLE, scl_m: 1'b1, scl_s: 1'b1, scl_d: 1'b1,
                sda_m: 1'b1, sda_s: 1'b1, sda_d: 1'b1, cnt: 4'h0,
                shift: tsm_pkg::BYTE_RESET, tx: tsm_pkg::BYTE_RESET,
                hi: tsm_pkg::BYTE_RESET, wbyte: tsm_pkg::BYTE_RESET,
                next: tsm_pkg::ADDR_RESET, rd_addr: tsm_pkg::ADDR_RESET,
                default: 1'b0};
        end else begin
            r <= n;
        end
    end

    // ----------------------------------------------------------------
    // Write buffer toward the array
    // ----------------------------------------------------------------
    tsm_fifo #(
        .WIDTH($bits(tsm_pkg::tsm_wr_word_s)),
        .DEPTH(WR_DEPTH)
    ) u_wr_fifo (
        .clk_sys(clk_sys),
        .rst_sync_n(rst_sync_n),
        .in_valid(push),
        .in_ready(fifo_ready),
        .in_data(push_word),
        .out_valid(mem_wr_valid),
        .out_ready(mem_wr_ready),
        .out_data(mem_wr_word)
    );

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign sda_out = 1'b0;
    assign sda_oe = r.oe;
    assign mem_rd_en = r.rd_en;
    assign mem_rd_addr = r.rd_addr;
    assign busy = (r.st != tsm_pkg::ST_IDLE);
endmodule // tsm_slave

//--- src/tsm_pkg.sv
// Shared constants, types and state layout of the two-wire memory slave.
// Assumes one system clock; the serial pins are sampled, never used as clocks.
package tsm_pkg;

    // ----------------------------------------------------------------
    // Widths and field positions
    // ----------------------------------------------------------------
    localparam int ADDR_W = 17;
    localparam int BYTE_W = 8;
    localparam int FIFO_DEPTH = 32;
    localparam int TYPE_MSB = 7;
    localparam int TYPE_LSB = 4;
    localparam int SEL_HIGH_POS = 3;
    localparam int SEL_LOW_POS = 2;
    localparam int TOP_ADDR_POS = 1;
    localparam int DIR_POS = 0;
    localparam logic DIR_READ = 1'b1;

    // ----------------------------------------------------------------
    // Bit slot counts within one byte frame
    // ----------------------------------------------------------------
    localparam logic [3:0] LAST_DATA_SLOT = 4'h7;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [3:0] ACK_DONE_SLOT = 4'h9;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_RESET = 17'h00000;
    localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEVADDR,
        ST_ADDR_HI,
        ST_ADDR_LO,
        ST_WDATA,
        ST_RDATA,
        ST_IGNORE
    } tsm_state_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [BYTE_W-1:0] data;
    } tsm_wr_word_s;

    typedef struct packed {
        logic scl_m;
        logic scl_s;
        logic scl_d;
        logic sda_m;
        logic sda_s;
        logic sda_d;
        logic wp_m;
        logic wp_s;
        logic selh_m;
        logic selh_s;
        logic sell_m;
        logic sell_s;
        tsm_state_e st;
        logic [3:0] cnt;
        logic [BYTE_W-1:0] shift;
        logic [BYTE_W-1:0] tx;
        logic [BYTE_W-1:0] hi;
        logic [BYTE_W-1:0] wbyte;
        logic top;
        logic dir;
        logic ack;
        logic mack;
        logic oe;
        logic [ADDR_W-1:0] next;
        logic [ADDR_W-1:0] rd_addr;
        logic rd_en;
    } tsm_state_s;

endpackage

//--- tb/tsm_slave_sva.sv
// Port checker for the two-wire memory slave.
// Assumes every port sits in the clk_sys domain; bound from the bench top file.
`timescale 1ns/1ns
module tsm_slave_sva (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic mem_wr_valid,
    input wire logic mem_wr_ready,
    input wire tsm_pkg::tsm_wr_word_s mem_wr_word,
    input wire logic mem_rd_en,
    input wire logic busy
);
    // ----------------------------------------------------------------
    // Port relations
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    property p_od; sda_oe |-> !sda_out; endproperty
    a_od: assert property (p_od) else $error("data pin driven high");
    property p_ack_len; $rose(sda_oe) |=> sda_oe [*3]; endproperty
    a_ack_len: assert property (p_ack_len) else $error("pull-down too short");
    property p_fall; $changed(sda_oe) |-> !$past(scl_in, 2); endproperty
    a_fall: assert property (p_fall) else $error("data changed near clock high");
    property p_oe_busy; sda_oe |-> busy; endproperty
    a_oe_busy: assert property (p_oe_busy) else $error("pull-down while idle");
    property p_stop; $rose(sda_in) && scl_in |-> ##[1:8] !busy; endproperty
    a_stop: assert property (p_stop) else $error("stop did not idle");
    property p_start; $fell(sda_in) && scl_in |-> ##[1:8] busy; endproperty
    a_start: assert property (p_start) else $error("start not taken");
    property p_rd_pulse; mem_rd_en |=> !mem_rd_en; endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("read enable too long");
    property p_rd_busy; mem_rd_en |-> busy; endproperty
    a_rd_busy: assert property (p_rd_busy) else $error("read while idle");
    property p_wr_hold;
        mem_wr_valid && !mem_wr_ready |=> mem_wr_valid && $stable(mem_wr_word);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write head dropped");
endmodule // tsm_slave_sva

//--- tb/tsm_master.sv
// Two-wire bus master model; it alone drives the serial clock.
// Assumes the bench resolves the pulled-up data line; calls start on a falling clk edge.
`timescale 1ns/1ns
module tsm_master (
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    // ----------------------------------------------------------------
    // Bus conditions and bits, 160 ns per bit
    // ----------------------------------------------------------------
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic start();
        #40 sda_low = 1'b0;
        #40 scl = 1'b1;
        #40 sda_low = 1'b1;
        #40 scl = 1'b0;
    endtask
    task automatic bit_io(input logic b, output logic s);
        #40 sda_low = !b;
        #40 scl = 1'b1;
        #80 s = sda;
        scl = 1'b0;
    endtask
    task automatic send(input logic [7:0] d, input int n, output logic ack);
        logic s;
        for (int i = 7; i > 7 - n; i--) bit_io(d[i], s);
        ack = 1'b1;
        if (n == 8) bit_io(1'b1, ack);
    endtask
    task automatic recv(input logic last, output logic [7:0] q);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, q[i]);
        bit_io(last, s);
    endtask
    task automatic stop();
        #40 sda_low = 1'b1;
        #40 scl = 1'b1;
        #40 sda_low = 1'b0;
    endtask
endmodule // tsm_master

//--- tb/tsm_slave_tb.sv
// Bench for the two-wire memory slave: master model, array model, checks.
// Assumes tsm_pkg, tsm_slave, tsm_master and tsm_slave_sva compiled first.
`timescale 1ns/1ns
module tsm_slave_tb;
    // ----------------------------------------------------------------
    // Harness
    // ----------------------------------------------------------------
    localparam logic [3:0] TCODE = 4'h6; // Arbitrary value
    logic clk_sys, rst_n, wp_in, wr_ready, scl, m_low, ack, rd_en, wr_valid, oe, sda_o, busy;
    logic [16:0] rd_addr;
    logic [7:0] rd_data, q;
    logic [7:0] mem [0:131071];
    logic [7:0] sh [0:131071];
    tsm_pkg::tsm_wr_word_s wr_word;
    int n_errors = 0;
    int checks = 0;
    int cyc = 0;
    wire logic sda = !(m_low || (oe && !sda_o));
    tsm_slave #(.TYPE_CODE(TCODE), .WR_DEPTH(32)) u_tsm_slave (
        .clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_o),
        .sda_oe(oe), .wp_in(wp_in), .select_pin_high(1'b1), .select_pin_low(1'b0),
        .mem_wr_valid(wr_valid), .mem_wr_ready(wr_ready), .mem_wr_word(wr_word),
        .mem_rd_en(rd_en), .mem_rd_addr(rd_addr), .mem_rd_data(rd_data), .busy(busy));
    tsm_master u_tsm_master (.scl(scl), .sda_low(m_low), .sda(sda));
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = !clk_sys;
    end
    always @(posedge clk_sys) begin
        if (rd_en) rd_data <= mem[rd_addr];
        if (wr_valid && wr_ready) mem[wr_word.addr] <= wr_word.data;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            print_verdict();
        end
    end
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [16:0] seen, input logic [16:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic aword(input logic [3:0] t, input logic [1:0] s, input logic [1:0] td);
        u_tsm_master.start();
        u_tsm_master.send({t, s, td}, 8, ack);
    endtask
    task automatic setadr(input logic [16:0] ad);
        aword(TCODE, 2'b10, {ad[16], 1'b0});
        chk("word ack", 17'(ack), 17'h00000);
        u_tsm_master.send(ad[15:8], 8, ack);
        chk("high ack", 17'(ack), 17'h00000);
        u_tsm_master.send(ad[7:0], 8, ack);
        chk("low ack", 17'(ack), 17'h00000);
    endtask
    task automatic commit(input logic [16:0] ad, input int n);
        for (int i = 0; i <= n; i++) chk("array", 17'(mem[17'(ad + i)]), 17'(sh[17'(ad + i)]));
    endtask
    task automatic wr(input logic [16:0] ad, input int n, input logic [7:0] d0);
        setadr(ad);
        for (int i = 0; i < n; i++) begin
            u_tsm_master.send(8'(d0 + i), 8, ack);
            chk("data ack", 17'(ack), 17'h00000);
            if (!wp_in) sh[17'(ad + i)] = 8'(d0 + i);
        end
        u_tsm_master.stop();
        commit(ad, n);
    endtask
    // Word with the address's top bit; master acks all bytes but the last
    task automatic rd(input logic [16:0] a0, input int n);
        aword(TCODE, 2'b10, {a0[16], 1'b1});
        chk("read ack", 17'(ack), 17'h00000);
        for (int i = 0; i < n; i++) begin
            u_tsm_master.recv(i == n - 1, q);
            chk("read data", 17'(q), 17'(sh[17'(a0 + i)]));
        end
        u_tsm_master.stop();
    endtask
    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        wp_in = 1'b0;
        wr_ready = 1'b1;
        rd_data = 8'h00;
        for (int i = 0; i < 131072; i++) mem[i] = 8'(i * 7);
        for (int i = 0; i < 131072; i++) sh[i] = 8'(i * 7);
        repeat (6) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (8) @(negedge clk_sys);
        chk("idle", 17'(busy), 17'h00000);
        wr(17'h12345, 1, 8'hA5);
        setadr(17'h12345);
        rd(17'h12345, 1);
        rd(17'h12346, 1);
        wr(17'h1FFFE, 3, 8'h30);
        setadr(17'h1FFFF);
        rd(17'h1FFFF, 3);
        wp_in = 1'b1;
        wr(17'h00100, 2, 8'h77);
        rd(17'h00102, 1);
        wp_in = 1'b0;
        aword(TCODE ^ 4'h1, 2'b10, 2'b00);
        chk("type nack", 17'(ack), 17'h00001);
        u_tsm_master.send(8'hA0, 8, ack);
        chk("ignored", 17'(ack), 17'h00001);
        aword(TCODE, 2'b01, 2'b00);
        chk("select nack", 17'(ack), 17'h00001);
        rd(17'h00103, 1);
        u_tsm_master.start();
        u_tsm_master.send({TCODE, 4'h4}, 4, ack);
        u_tsm_master.stop();
        repeat (10) @(negedge clk_sys);
        chk("abort idle", 17'(busy), 17'h00000);
        wr_ready = 1'b0;
        setadr(17'h00200);
        for (int i = 0; i < 33; i++) begin
            u_tsm_master.send(8'(i), 8, ack);
            chk("fill ack", 17'(ack), 17'(i == 32));
            if (i < 32) sh[17'(17'h00200 + i)] = 8'(i);
        end
        u_tsm_master.stop();
        chk("stalled", 17'(wr_valid), 17'h00001);
        wr_ready = 1'b1;
        repeat (40) @(negedge clk_sys);
        commit(17'h00200, 32);
        print_verdict();
    end
endmodule // tsm_slave_tb

bind tsm_slave tsm_slave_sva u_tsm_slave_sva (
    .clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .mem_wr_valid(mem_wr_valid),
    .mem_wr_ready(mem_wr_ready), .mem_wr_word(mem_wr_word), .mem_rd_en(mem_rd_en),
    .busy(busy));
